// ===== core/dsp_frame_port.sv
`timescale 1ns/10ps
module dsp_frame_port (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        clk_en,
   input  wire logic        sync_b,
   input  wire logic        sclk,
   input  wire logic        din,
   input  wire logic        mem_busy,
   output logic             serial_out_od_o,
   output logic             serial_out_od_oe,
   output logic             ready_od_o,
   output logic             ready_od_oe,
   output logic [9:0]       wiper_register,
   output logic             frame_commit,
   output logic             frame_abort,
   output logic [3:0]       commit_cmd,
   output logic [9:0]       commit_data
);
   dsp_pkg::dsp_pins_t pins_raw;
   dsp_pkg::dsp_pins_t pins;

   assign pins_raw = '{sync_b: sync_b, sclk: sclk, din: din};

   dsp_sync u_sync (
      .clk    (clk),
      .rst_b  (rst_b),
      .en     (clk_en),
      .pins_i (pins_raw),
      .pins_o (pins)
   );

   dsp_pkg::dsp_state_t state_q;
   dsp_pkg::dsp_state_t state_d;
   logic                sync_prev_q;
   logic                sync_prev_d;
   logic                sclk_prev_q;
   logic                sclk_prev_d;
   logic [15:0]         shift_q;
   logic [15:0]         shift_d;
   logic [3:0]          cnt_q;
   logic [3:0]          cnt_d;
   logic [9:0]          wiper_q;
   logic [9:0]          wiper_d;
   logic                rd_pend_q;
   logic                rd_pend_d;
   logic                sdo_q;
   logic                sdo_d;
   logic                rdy_q;
   logic                rdy_d;
   logic                commit_q;
   logic                commit_d;
   logic                abort_q;
   logic                abort_d;
   dsp_pkg::dsp_word_t  word_q;
   dsp_pkg::dsp_word_t  word_d;
   logic                sync_fall;
   logic                sync_rise;
   logic                sclk_fall;
   dsp_pkg::dsp_word_t  rx;

   assign sync_fall = sync_prev_q & ~pins.sync_b;
   assign sync_rise = ~sync_prev_q & pins.sync_b;
   assign sclk_fall = sclk_prev_q & ~pins.sclk;
   // Word layout: two zeros, command, data, MSB first
   assign rx = '{cmd:  shift_q[dsp_pkg::CMD_LSB +: dsp_pkg::CMD_W],
                 data: shift_q[dsp_pkg::DATA_W-1:0]};

   // Edge history runs in every state, so no edge is lost at a state change
   always_comb
   begin
      sync_prev_d = pins.sync_b;
      sclk_prev_d = pins.sclk;
   end

   // Clock history resets low, so an idle-low clock gives no false edge
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sync_prev_q <= 1'b1;
         sclk_prev_q <= 1'b0;
      end
      else if (clk_en)
      begin
         sync_prev_q <= sync_prev_d;
         sclk_prev_q <= sclk_prev_d;
      end
   end

   // Frame end: commit only on whole words, any other started frame aborts
   always_comb
   begin
      commit_d = 1'b0;
      abort_d  = 1'b0;
      word_d   = word_q;
      if (state_q != dsp_pkg::ST_IDLE && sync_rise)
      begin
         if (state_q == dsp_pkg::ST_FULL && cnt_q == '0)
         begin
            commit_d = 1'b1;
            word_d   = rx;
         end
         else
         begin
            abort_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         commit_q <= 1'b0;
         abort_q  <= 1'b0;
         word_q   <= '0;
      end
      else if (clk_en)
      begin
         commit_q <= commit_d;
         abort_q  <= abort_d;
         word_q   <= word_d;
      end
   end

   // Shifter, bit counter, wiper and line state
   always_comb
   begin
      state_d   = state_q;
      shift_d   = shift_q;
      cnt_d     = cnt_q;
      wiper_d   = wiper_q;
      rd_pend_d = rd_pend_q;
      sdo_d     = sdo_q;
      rdy_d     = rdy_q;
      case (state_q)
         dsp_pkg::ST_IDLE:
         begin
            // A new frame only starts while no memory operation runs; a started frame keeps shifting
            if (sync_fall && !mem_busy)
            begin
               state_d = dsp_pkg::ST_SHIFT;
               cnt_d   = '0;
               rdy_d   = 1'b0;
               // Readback replaces chained data in the frame after a read
               if (rd_pend_q)
               begin
                  shift_d   = {6'h00, wiper_q};
                  rd_pend_d = 1'b0;
               end
               sdo_d = shift_d[dsp_pkg::FRAME_BITS-1];
            end
         end
         dsp_pkg::ST_SHIFT, dsp_pkg::ST_FULL:
         begin
            if (sync_rise)
            begin
               state_d = dsp_pkg::ST_IDLE;
               rdy_d   = 1'b1;
               // Only a committed word may touch the wiper
               if (commit_d)
               begin
                  case (rx.cmd)
                     dsp_pkg::CMD_WR_WIPER: wiper_d   = rx.data;
                     dsp_pkg::CMD_RD_WIPER: rd_pend_d = 1'b1;
                     dsp_pkg::CMD_REFRESH:  wiper_d   = dsp_pkg::WIPER_RESET;
                     default:               wiper_d   = wiper_q;
                  endcase
               end
            end
            else if (sclk_fall)
            begin
               // MSB leaves as a new bit enters: a 16-clock delay line
               shift_d = {shift_q[dsp_pkg::FRAME_BITS-2:0], pins.din};
               sdo_d   = shift_q[dsp_pkg::FRAME_BITS-2];
               // Count wraps every word, so 32 clocks end like 16
               cnt_d   = cnt_q + 4'h1;
               if (cnt_q == 4'hF)
               begin
                  state_d = dsp_pkg::ST_FULL;
               end
            end
         end
         default:
         begin
            state_d = dsp_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_q   <= dsp_pkg::ST_IDLE;
         shift_q   <= dsp_pkg::SHIFT_RESET;
         cnt_q     <= '0;
         wiper_q   <= dsp_pkg::WIPER_RESET;
         rd_pend_q <= 1'b0;
         sdo_q     <= 1'b1;
         rdy_q     <= 1'b1;
      end
      else if (clk_en)
      begin
         state_q   <= state_d;
         shift_q   <= shift_d;
         cnt_q     <= cnt_d;
         wiper_q   <= wiper_d;
         rd_pend_q <= rd_pend_d;
         sdo_q     <= sdo_d;
         rdy_q     <= rdy_d;
      end
   end

   // Open drain: only ever pull low, pull-up lives on the board
   assign serial_out_od_o  = 1'b0;
   assign serial_out_od_oe = ~sdo_q;
   assign ready_od_o       = 1'b0;
   assign ready_od_oe      = ~(rdy_q & ~mem_busy);
   assign wiper_register   = wiper_q;
   assign frame_commit     = commit_q;
   assign frame_abort      = abort_q;
   assign commit_cmd       = word_q.cmd;
   assign commit_data      = word_q.data;
endmodule

// ===== core/dsp_pkg.sv
package dsp_pkg;
   localparam int          FRAME_BITS   = 16;
   localparam int          CNT_W        = 4;
   localparam int          DATA_W       = 10;
   localparam int          CMD_W        = 4;
   localparam int          CMD_LSB      = 10;
   localparam int          CLK_MHZ      = 50;
   localparam int          SCLK_MAX_MHZ = 50;
   localparam logic [9:0]  WIPER_RESET  = 10'h200;
   localparam logic [15:0] SHIFT_RESET  = 16'h0000;
   localparam logic [3:0]  CMD_NOP      = 4'h0;
   localparam logic [3:0]  CMD_WR_WIPER = 4'h1;
   localparam logic [3:0]  CMD_RD_WIPER = 4'h2;
   localparam logic [3:0]  CMD_STORE    = 4'h3;
   localparam logic [3:0]  CMD_REFRESH  = 4'h4;

   typedef struct packed {
      logic sync_b;
      logic sclk;
      logic din;
   } dsp_pins_t;

   typedef struct packed {
      logic [3:0] cmd;
      logic [9:0] data;
   } dsp_word_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SHIFT = 2'b01,
      ST_FULL  = 2'b11
   } dsp_state_t;
endpackage

// ===== core/dsp_sync.sv
`timescale 1ns/10ps
module dsp_sync (
   input  wire logic               clk,
   input  wire logic               rst_b,
   input  wire logic               en,
   input  wire dsp_pkg::dsp_pins_t pins_i,
   output dsp_pkg::dsp_pins_t      pins_o
);
   dsp_pkg::dsp_pins_t meta_q;
   dsp_pkg::dsp_pins_t meta_d;
   dsp_pkg::dsp_pins_t sync_q;
   dsp_pkg::dsp_pins_t sync_d;

   always_comb
   begin
      meta_d = en ? pins_i : meta_q;
      sync_d = en ? meta_q : sync_q;
   end

   // Sync idles high so reset never looks like a frame start
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_q <= '{sync_b: 1'b1, sclk: 1'b0, din: 1'b0};
         sync_q <= '{sync_b: 1'b1, sclk: 1'b0, din: 1'b0};
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign pins_o = sync_q;
endmodule

// ===== tb/dsp_frame_port_properties.sv
`timescale 1ns/10ps
module dsp_frame_port_properties (
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic       mem_busy,
   input wire logic       sync_b,
   input wire logic       serial_out_od_o,
   input wire logic       ready_od_o,
   input wire logic       ready_od_oe,
   input wire logic [9:0] wiper_register,
   input wire logic       frame_commit,
   input wire logic       frame_abort,
   input wire logic [3:0] commit_cmd,
   input wire logic [9:0] commit_data
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_one; !(frame_commit && frame_abort); endproperty
   a_one: assert property (p_one) else $error("commit and abort together");
   property p_cp; frame_commit |=> !frame_commit; endproperty
   a_cp: assert property (p_cp) else $error("commit pulse too long");
   property p_sy; frame_commit || frame_abort |-> $past(sync_b, 3); endproperty
   a_sy: assert property (p_sy) else $error("frame end without sync high");
   property p_wc; $changed(wiper_register) |-> frame_commit; endproperty
   a_wc: assert property (p_wc) else $error("wiper moved off commit");
   property p_wr; frame_commit && commit_cmd == 4'h1 |-> wiper_register == commit_data;
   endproperty
   a_wr: assert property (p_wr) else $error("wiper not written");
   property p_od; serial_out_od_o == 1'b0 && ready_od_o == 1'b0; endproperty
   a_od: assert property (p_od) else $error("open-drain line driven high");
   property p_bz; mem_busy ##1 mem_busy |-> ready_od_oe; endproperty
   a_bz: assert property (p_bz) else $error("ready released while busy");
   property p_rl; frame_commit && !mem_busy |-> !ready_od_oe; endproperty
   a_rl: assert property (p_rl) else $error("ready not released");
endmodule

// ===== tb/dsp_host_model.sv
`timescale 1ns/10ps
module dsp_host_model (
   input  wire logic  clk,
   input  wire logic  so,
   output logic       sync_b,
   output logic       sclk,
   output logic       din,
   output logic [15:0] rx
);
   initial
   begin
      sync_b = 1'b1;
      sclk   = 1'b0;
      din    = 1'b0;
      rx     = 16'h0000;
   end
   // Phases of 4 clk stay clear of the 3-clk sampling delay
   task automatic send(input logic [31:0] w, input int n);
      @(posedge clk);
      #1 sync_b = 1'b0;
      repeat (4) @(posedge clk);
      for (int i = n - 1; i >= 0; i--)
      begin
         #1 din = w[i];
         sclk = 1'b1;
         repeat (4) @(posedge clk);
         #1 rx = {rx[14:0], so};
         sclk = 1'b0;
         repeat (4) @(posedge clk);
      end
      #1 sync_b = 1'b1;
      din = ~din;
   endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/10ps
module tb;
   logic       clk = 1'b0;
   logic       rst_b = 1'b0;
   logic       mem_busy = 1'b0;
   logic       clk_en = 1'b1;
   logic       sync_b, sclk, din, serial_out_od_oe, ready_od_oe, frame_commit, frame_abort;
   logic [9:0] wiper_register, commit_data;
   logic [3:0] commit_cmd;
   logic [15:0] rx;
   int         fail_count = 0;
   int         tests_run = 0;
   wire        so = serial_out_od_oe ? 1'b0 : 1'b1;
   always #10 clk = ~clk;
   dsp_frame_port i_dsp_frame_port (.clk, .rst_b, .clk_en, .sync_b, .sclk, .din,
      .mem_busy, .serial_out_od_o(), .serial_out_od_oe, .ready_od_o(), .ready_od_oe,
      .wiper_register, .frame_commit, .frame_abort, .commit_cmd, .commit_data);
   dsp_host_model i_dsp_host_model (.clk, .so, .sync_b, .sclk, .din, .rx);
   task automatic test_done();
      if (fail_count == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input bit ok, input string m);
      tests_run++;
      if (!ok)
      begin
         fail_count++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task automatic xfer(input logic [31:0] w, input int n, input bit ec, input bit ea);
      bit c;
      bit a;
      c = 1'b0;
      a = 1'b0;
      i_dsp_host_model.send(w, n);
      repeat (12)
      begin
         @(posedge clk);
         #1 c |= frame_commit === 1'b1;
         a |= frame_abort === 1'b1;
      end
      chk(c == ec && a == ea, "frame end pulse");
      if (ec && !c)
         test_done();
   endtask
   task automatic t_write();
      xfer(32'h0555, 16, 1, 0);
      chk(wiper_register === 10'h155 && commit_cmd === dsp_pkg::CMD_WR_WIPER, "write");
      chk(commit_data === 10'h155, "commit data");
   endtask
   task automatic t_abort();
      xfer(32'h07FF, 15, 0, 1);
      xfer(32'h0BFFF, 17, 0, 1);
      chk(wiper_register === 10'h155, "abort changed wiper");
   endtask
   task automatic t_chain();
      xfer({16'h04AA, 16'h07C3}, 32, 1, 0);
      chk(wiper_register === 10'h3C3 && rx === 16'h04AA, "chain");
   endtask
   task automatic t_cmds();
      xfer(32'h0800, 16, 1, 0);
      xfer(32'h0000, 16, 1, 0);
      chk(rx[9:0] === 10'h3C3, "readback");
      xfer(32'h0C00, 16, 1, 0);
      xfer(32'h1000, 16, 1, 0);
      chk(wiper_register === dsp_pkg::WIPER_RESET, "refresh");
   endtask
   task automatic t_busy();
      mem_busy = 1'b1;
      xfer(32'h0555, 16, 0, 0);
      chk(ready_od_oe === 1'b1 && wiper_register === 10'h200, "busy");
      mem_busy = 1'b0;
   endtask
   // Frozen block must not see a frame at all
   task automatic t_freeze();
      clk_en = 1'b0;
      xfer(32'h07C3, 16, 0, 0);
      chk(wiper_register === 10'h200, "frozen wiper moved");
      clk_en = 1'b1;
   endtask
   task automatic t_reset();
      xfer(32'h0555, 16, 1, 0);
      rst_b = 1'b0;
      repeat (2) @(posedge clk);
      #1 rst_b = 1'b1;
      chk(wiper_register === dsp_pkg::WIPER_RESET, "mid-run reset wiper");
      chk(ready_od_oe === 1'b0 && serial_out_od_oe === 1'b0, "mid-run reset lines");
      repeat (4) @(posedge clk);
      xfer(32'h07C3, 16, 1, 0);
      chk(wiper_register === 10'h3C3, "write after reset");
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      #1 rst_b = 1'b1;
      chk(wiper_register === 10'h200 && serial_out_od_oe === 1'b0, "reset");
      repeat (4) @(posedge clk);
      t_write();
      t_abort();
      t_chain();
      t_cmds();
      t_busy();
      t_freeze();
      t_reset();
      test_done();
   end
endmodule
bind dsp_frame_port dsp_frame_port_properties i_dsp_frame_port_properties (.clk, .rst_b,
   .mem_busy, .sync_b, .serial_out_od_o, .ready_od_o, .ready_od_oe, .wiper_register,
   .frame_commit, .frame_abort, .commit_cmd, .commit_data);
